// [core/bpsr_pkg.sv]
// package: constants and types for the buck pair set-point register bank
// Function
// - range bit 0 decodes step field as low range up to code 0111111, 1.9750 V.
// - range bit 1 decodes high range to 3.3000 V at 1110010; 1110011 up reserved.
// - normal set points at 0x3C for A and 0x43 for B.
// - standby set points at 0x3D for A and 0x44 for B.
// - sleep set points at 0x3E for A and 0x45 for B.
// - switching-mode selectors at 0x3F for A and 0x46 for B.
// - configuration registers at 0x40 for A and 0x47 for B.
// - normal set point bits 5:0 read/write, reset 0x00.
// - bit 6 is read-only range, set only by one-time or test-mode configuration.
// - initial normal range bit copied into standby and sleep range bits.
`default_nettype none
package bpsr_pkg;
  localparam logic [7:0] BPSR_ADDR_A_NORMAL = 8'h3C;
  localparam logic [7:0] BPSR_ADDR_A_STANDBY = 8'h3D;
  localparam logic [7:0] BPSR_ADDR_A_SLEEP = 8'h3E;
  localparam logic [7:0] BPSR_ADDR_A_MODE = 8'h3F;
  localparam logic [7:0] BPSR_ADDR_A_CONFIG = 8'h40;
  localparam logic [7:0] BPSR_ADDR_B_NORMAL = 8'h43;
  localparam logic [7:0] BPSR_ADDR_B_STANDBY = 8'h44;
  localparam logic [7:0] BPSR_ADDR_B_SLEEP = 8'h45;
  localparam logic [7:0] BPSR_ADDR_B_MODE = 8'h46;
  localparam logic [7:0] BPSR_ADDR_B_CONFIG = 8'h47;
  localparam int BPSR_NUM_REGS = 10;
  localparam int BPSR_IDX_W = 4;
  localparam logic [5:0] BPSR_STEP_RESET = 6'h00;
  localparam logic [7:0] BPSR_REG_RESET = 8'h00;
  localparam logic [7:0] BPSR_SETPOINT_WMASK = 8'h3F;
  localparam logic [7:0] BPSR_FULL_WMASK = 8'hFF;
  localparam int BPSR_RANGE_BIT = 6;
  localparam logic [5:0] BPSR_HIGH_LAST_STEP = 6'h32;
  localparam logic [12:0] BPSR_LOW_BASE_MV = 13'h0190;
  localparam logic [12:0] BPSR_HIGH_BASE_MV = 13'h0320;
  localparam logic [12:0] BPSR_LOW_STEP_MV = 13'h0019;
  localparam logic [12:0] BPSR_HIGH_STEP_MV = 13'h0032;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bpsr_req_t;

  typedef struct packed {
    logic valid;
    logic [12:0] millivolts;
  } bpsr_level_t;
endpackage : bpsr_pkg
`default_nettype wire

// [core/bpsr_reg_cell.sv]
// one 8-bit register with a write mask and a read-only range bit
`timescale 1ns/1ps
`default_nettype none
module bpsr_reg_cell #(
  parameter logic [7:0] WMASK = 8'hFF,
  parameter bit HAS_RANGE = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  input wire logic range_load_i,
  input wire logic range_i,
  output logic [7:0] q_o
);
  logic [7:0] q_reg;
  logic [7:0] q_next;

  always_comb
  begin
    q_next = q_reg;
    if (we_i)
    begin
      q_next = (q_reg & ~WMASK) | (wdata_i & WMASK);
    end
    if (HAS_RANGE && range_load_i)
    begin
      q_next[bpsr_pkg::BPSR_RANGE_BIT] = range_i;
    end
    if (!HAS_RANGE)
    begin
      q_next[bpsr_pkg::BPSR_RANGE_BIT] = q_next[bpsr_pkg::BPSR_RANGE_BIT] & WMASK[bpsr_pkg::BPSR_RANGE_BIT];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      q_reg <= bpsr_pkg::BPSR_REG_RESET;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule : bpsr_reg_cell
`default_nettype wire

// [core/bpsr_regs.sv]
// register bank for one pair of buck channels, with set-point decoding
`timescale 1ns/1ps
`default_nettype none
module bpsr_regs (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire bpsr_pkg::bpsr_req_t req_i,
  input wire logic [1:0] otp_range_i,
  input wire logic otp_load_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [7:0] chan_a_mode_o,
  output logic [7:0] chan_a_config_o,
  output logic [7:0] chan_b_mode_o,
  output logic [7:0] chan_b_config_o,
  output bpsr_pkg::bpsr_level_t [5:0] level_o
);
  // index order: A normal, standby, sleep, mode, config, then B the same
  localparam logic [7:0] ADDRS [bpsr_pkg::BPSR_NUM_REGS] = '{
    bpsr_pkg::BPSR_ADDR_A_NORMAL, bpsr_pkg::BPSR_ADDR_A_STANDBY, bpsr_pkg::BPSR_ADDR_A_SLEEP,
    bpsr_pkg::BPSR_ADDR_A_MODE, bpsr_pkg::BPSR_ADDR_A_CONFIG,
    bpsr_pkg::BPSR_ADDR_B_NORMAL, bpsr_pkg::BPSR_ADDR_B_STANDBY, bpsr_pkg::BPSR_ADDR_B_SLEEP,
    bpsr_pkg::BPSR_ADDR_B_MODE, bpsr_pkg::BPSR_ADDR_B_CONFIG};

  logic [7:0] q [bpsr_pkg::BPSR_NUM_REGS];
  logic [bpsr_pkg::BPSR_NUM_REGS-1:0] hit;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  bpsr_pkg::bpsr_level_t [5:0] level_reg;
  bpsr_pkg::bpsr_level_t [5:0] level_next;
  logic [7:0] out_reg [4];
  logic [7:0] out_next [4];

  genvar g;
  generate
    for (g = 0; g < bpsr_pkg::BPSR_NUM_REGS; g++)
    begin : g_cell
      localparam bit IS_SP = ((g % 5) < 3);
      assign hit[g] = (req_i.addr == ADDRS[g]);
      bpsr_reg_cell #(
        .WMASK(IS_SP ? bpsr_pkg::BPSR_SETPOINT_WMASK : bpsr_pkg::BPSR_FULL_WMASK),
        .HAS_RANGE(IS_SP)
      ) u_cell (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .we_i(req_i.wr && hit[g]),
        .wdata_i(req_i.wdata),
        .range_load_i(otp_load_i),
        .range_i(otp_range_i[g / 5]),
        .q_o(q[g])
      );
    end
  endgenerate

  // decode of a 7-bit code; reserved high codes report invalid
  function automatic bpsr_pkg::bpsr_level_t decode(input logic [7:0] code);
    bpsr_pkg::bpsr_level_t r;
    r.valid = 1'b1;
    if (code[bpsr_pkg::BPSR_RANGE_BIT])
    begin
      r.millivolts = 13'(bpsr_pkg::BPSR_HIGH_BASE_MV + 13'(code[5:0]) * bpsr_pkg::BPSR_HIGH_STEP_MV);
      if (code[5:0] > bpsr_pkg::BPSR_HIGH_LAST_STEP)
      begin
        r.valid = 1'b0;
        r.millivolts = 13'h0000;
      end
    end
    else
    begin
      r.millivolts = 13'(bpsr_pkg::BPSR_LOW_BASE_MV + 13'(code[5:0]) * bpsr_pkg::BPSR_LOW_STEP_MV);
    end
    return r;
  endfunction : decode

  always_comb
  begin
    rdata_next = 8'h00; // unmapped reads return zero
    for (int i = 0; i < bpsr_pkg::BPSR_NUM_REGS; i++)
    begin
      if (hit[i])
      begin
        rdata_next = q[i];
      end
    end
    rdata_next[7] = rdata_next[7] & ~(|(hit & 10'h0E7));
    rvalid_next = req_i.rd;
    for (int i = 0; i < 6; i++)
    begin
      level_next[i] = decode(q[(i / 3) * 5 + (i % 3)]);
    end
    out_next[0] = q[3];
    out_next[1] = q[4];
    out_next[2] = q[8];
    out_next[3] = q[9];
  end

  // registered outputs so the analogue side never sees decode glitches
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      level_reg <= '0;
      for (int i = 0; i < 4; i++)
      begin
        out_reg[i] <= 8'h00;
      end
    end
    else
    begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      level_reg <= level_next;
      for (int i = 0; i < 4; i++)
      begin
        out_reg[i] <= out_next[i];
      end
    end
  end

  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign level_o = level_reg;
  assign chan_a_mode_o = out_reg[0];
  assign chan_a_config_o = out_reg[1];
  assign chan_b_mode_o = out_reg[2];
  assign chan_b_config_o = out_reg[3];
endmodule : bpsr_regs
`default_nettype wire

// [verification/bpsr_host.sv]
// host model issuing register requests
`timescale 1ns/1ps
`default_nettype none
module bpsr_host (
  input wire logic ref_clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output bpsr_pkg::bpsr_req_t req_o
);
  initial req_o = '0;
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge ref_clk_i);
    #1 req_o = {w, !w, a, d};
    @(posedge ref_clk_i);
    // idle: strobes cleared, address and data inverted so stale values never look valid
    #1 req_o = {2'h0, ~a, ~d};
    q = w ? 8'h00 : (rvalid_i ? rdata_i : 8'hEE);
  endtask : xfer
endmodule : bpsr_host
`default_nettype wire

// [verification/bpsr_regs_chk.sv]
// port assertions for the set-point register bank
`timescale 1ns/1ps
`default_nettype none
module bpsr_regs_chk (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire bpsr_pkg::bpsr_req_t req_i,
  input wire logic [1:0] otp_range_i,
  input wire logic otp_load_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [7:0] chan_a_mode_o,
  input wire logic [7:0] chan_a_config_o,
  input wire logic [7:0] chan_b_mode_o,
  input wire logic [7:0] chan_b_config_o,
  input wire bpsr_pkg::bpsr_level_t [5:0] level_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_answer: assert property (req_i.rd |=> rvalid_o) else $error("no read answer");
  a_no_stray: assert property (!req_i.rd |=> !rvalid_o) else $error("stray read valid");
  a_unused_bit: assert property (req_i.rd && req_i.addr inside {8'h3C, 8'h3D, 8'h3E, 8'h43, 8'h44, 8'h45}
    |=> !rdata_o[7]) else $error("unused bit set");
  a_mode_a: assert property (req_i.wr && req_i.addr == 8'h3F |-> ##2 chan_a_mode_o == $past(req_i.wdata, 2))
    else $error("mode a wrong");
  a_conf_a: assert property (req_i.wr && req_i.addr == 8'h40 |-> ##2 chan_a_config_o == $past(req_i.wdata, 2))
    else $error("config a wrong");
  a_mode_b: assert property (req_i.wr && req_i.addr == 8'h46 |-> ##2 chan_b_mode_o == $past(req_i.wdata, 2))
    else $error("mode b wrong");
  a_conf_b: assert property (req_i.wr && req_i.addr == 8'h47 |-> ##2 chan_b_config_o == $past(req_i.wdata, 2))
    else $error("config b wrong");
  a_unmapped_zero: assert property (req_i.rd && req_i.addr == 8'h41 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_level_ceiling: assert property (level_o[3].valid |-> level_o[3].millivolts <= 13'h0CE4)
    else $error("level above high range");
  c_wr_norm: cover property (req_i.wr && req_i.addr == 8'h3C);
  c_load: cover property (otp_load_i);
  c_high: cover property (rvalid_o && rdata_o[6]);
endmodule : bpsr_regs_chk
bind bpsr_regs bpsr_regs_chk u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
  .otp_range_i(otp_range_i), .otp_load_i(otp_load_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .chan_a_mode_o(chan_a_mode_o), .chan_a_config_o(chan_a_config_o), .chan_b_mode_o(chan_b_mode_o),
  .chan_b_config_o(chan_b_config_o), .level_o(level_o));
`default_nettype wire

// [verification/bpsr_regs_tb_top.sv]
// testbench for the set-point register bank
`timescale 1ns/1ps
`default_nettype none
module bpsr_regs_tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] otp_range_i = 2'h2;
  logic otp_load_i = 1'b0;
  logic rvalid_o;
  logic [7:0] rdata_o, a_mode, a_conf, b_mode, b_conf, q;
  bpsr_pkg::bpsr_req_t req_i;
  bpsr_pkg::bpsr_level_t [5:0] level_o;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] adr [10] = '{8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47};
  bpsr_regs DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .otp_range_i(otp_range_i),
    .otp_load_i(otp_load_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .chan_a_mode_o(a_mode),
    .chan_a_config_o(a_conf), .chan_b_mode_o(b_mode), .chan_b_config_o(b_conf), .level_o(level_o));
  bpsr_host u_host (.ref_clk_i(ref_clk_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o), .req_o(req_i));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // hang guard, far beyond the roughly 74 cycles needed
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    u_host.xfer(1'b0, 8'h3C, 8'h00, q);
    chk("reset", 8'h00, q);
    @(posedge ref_clk_i);
    #1 otp_load_i = 1'b1;
    @(posedge ref_clk_i);
    #1 otp_load_i = 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      u_host.xfer(1'b1, adr[i], 8'hFF, q);
      u_host.xfer(1'b0, adr[i], 8'h00, q);
      chk("reg", (i % 5 > 2) ? 8'hFF : {1'b0, i > 4, 6'h3F}, q);
    end
    chk("a_mode", 8'hFF, a_mode);
    chk("a_conf", 8'hFF, a_conf);
    chk("b_mode", 8'hFF, b_mode);
    chk("b_conf", 8'hFF, b_conf);
    chk("lvl_a", {3'h1, 13'h07B7}, level_o[0]);
    chk("lvl_a_stby", {3'h1, 13'h07B7}, level_o[1]);
    chk("lvl_a_sleep", {3'h1, 13'h07B7}, level_o[2]);
    chk("lvl_b_rsvd", 16'h0000, level_o[3]);
    chk("lvl_b_stby", 16'h0000, level_o[4]);
    chk("lvl_b_sleep", 16'h0000, level_o[5]);
    u_host.xfer(1'b1, 8'h43, 8'h32, q);
    @(posedge ref_clk_i);
    #1 chk("lvl_b", {3'h1, 13'h0CE4}, level_o[3]);
    u_host.xfer(1'b0, 8'h43, 8'h00, q);
    chk("b_norm", 8'h72, q);
    u_host.xfer(1'b1, 8'h41, 8'hA5, q);
    u_host.xfer(1'b0, 8'h41, 8'h00, q);
    chk("unmapped", 8'h00, q);
    // mid-run reset must clear range bits and registered outputs alike
    @(posedge ref_clk_i);
    #1 rst_n_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    u_host.xfer(1'b0, 8'h43, 8'h00, q);
    chk("b_norm_rst", 8'h00, q);
    chk("a_mode_rst", 8'h00, a_mode);
    report_and_stop();
  end
endmodule : bpsr_regs_tb_top
`default_nettype wire
